// >>> src/cec_consts.vh
// constants for the comparator edge control block
`ifndef CEC_CONSTS_VH
`define CEC_CONSTS_VH
`define CEC_NCMP 3
`define CEC_OFS_CTRL0 12'h000
`define CEC_OFS_CTRL1 12'h004
`define CEC_OFS_CTRL2 12'h008
`define CEC_OFS_MODE0 12'h010
`define CEC_OFS_MODE1 12'h014
`define CEC_OFS_MODE2 12'h018
`define CEC_OFS_XIE 12'h020
`define CEC_OFS_PIN 12'h024
`define CEC_OFS_RST 12'h028
// control register fields
`define CEC_B_EN 7
`define CEC_B_OUT 6
`define CEC_B_RIF 5
`define CEC_B_FIF 4
`define CEC_F_HYP 3:2
`define CEC_F_HYN 1:0
// mode register fields
`define CEC_B_RIE 5
`define CEC_B_FIE 4
`define CEC_F_MD 1:0
`define CEC_CTRL_RST 8'h00
`define CEC_MODE_RST 8'h02
`endif

// >>> src/cec_sync.v
// two-flop synchroniser bank for the comparator outputs
`timescale 1ns/1ps
`default_nettype none
module cec_sync #(
    parameter W = 3
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // data
    input wire [W-1:0] d,
    output reg [W-1:0] q
);
reg [W-1:0] s1_r;
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        s1_r <= {W{1'b0}};
        q <= {W{1'b0}};
    end else begin
        s1_r <= d;
        q <= s1_r;
    end
end
endmodule // cec_sync
`default_nettype wire

// >>> src/cec_top.v
// comparator edge control: apb registers, edge flags, irq, pin and reset outputs
// Summary of operation
// - each comparator powered on when its enable bit is 1, off when 0
// - disabled comparator drives logic low to its port pin
// - software reads the current comparator result anytime via output state bit
// - interrupt on rise only if rise enable set, on fall if fall enable
// - falling edge sets fall flag, rising edge sets rise flag
// - interrupt also needs the comparator bit in the extended enable register
// - two-bit mode field selects response time; slower saves power
// - control bits 3..0 hold positive and negative hysteresis selects
// - pin driver per comparator selectable open-drain or push-pull
// - comparator output may act as a device reset source
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "cec_consts.vh"
module cec_top #(
    parameter NCMP = `CEC_NCMP
) (
    // apb
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // analog comparator cores
    input wire [NCMP-1:0] cmp_raw,
    output reg [NCMP-1:0] cmp_power_on,
    output reg [2*NCMP-1:0] response_time_select,
    output reg [2*NCMP-1:0] pos_hysteresis_select,
    output reg [2*NCMP-1:0] neg_hysteresis_select,
    // port pins
    output reg [NCMP-1:0] cmp_pin_out,
    output reg [NCMP-1:0] cmp_pin_oe,
    // system
    output reg cmp_reset_req,
    output reg cmp_irq
);
reg [7:0] ctrl_r [0:NCMP-1];
reg [7:0] mode_r [0:NCMP-1];
reg [NCMP-1:0] xie_r;
reg [NCMP-1:0] pin_od_r;
reg [NCMP-1:0] rst_en_r;
reg [NCMP-1:0] prev_r;
wire [NCMP-1:0] cmp_sync;
reg [NCMP-1:0] rise_ev;
reg [NCMP-1:0] fall_ev;
reg [NCMP-1:0] cmp_output_state;
reg [NCMP-1:0] irq_nxt;
reg [31:0] rd_nxt;
reg addr_ok;
integer i;
integer c;

wire wr_en = psel && penable && pwrite;
assign pready = 1'b1;
assign pslverr = psel && penable && !addr_ok;

// index of a per-comparator register, or -1
function integer reg_idx;
    input [11:0] a;
    input [11:0] base;
    begin
        if (a >= base && a < base + 12'h00C && a[1:0] == 2'b00)
            reg_idx = (a - base) >> 2;
        else
            reg_idx = -1;
    end
endfunction

cec_sync #(.W(NCMP)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(cmp_raw),
    .q(cmp_sync)
);

// state is forced low while disabled
always @* begin
    for (c = 0; c < NCMP; c = c + 1) begin
        cmp_output_state[c] = ctrl_r[c][`CEC_B_EN] & cmp_sync[c];
        rise_ev[c] = cmp_output_state[c] & ~prev_r[c];
        fall_ev[c] = ~cmp_output_state[c] & prev_r[c];
        irq_nxt[c] = xie_r[c] &
            ((ctrl_r[c][`CEC_B_RIF] & mode_r[c][`CEC_B_RIE]) |
             (ctrl_r[c][`CEC_B_FIF] & mode_r[c][`CEC_B_FIE]));
    end
end

always @* begin
    addr_ok = 1'b1;
    rd_nxt = 32'h00000000;
    if (reg_idx(paddr, `CEC_OFS_CTRL0) >= 0) begin
        rd_nxt[7:0] = ctrl_r[reg_idx(paddr, `CEC_OFS_CTRL0)];
        rd_nxt[`CEC_B_OUT] = cmp_output_state[reg_idx(paddr, `CEC_OFS_CTRL0)];
    end else if (reg_idx(paddr, `CEC_OFS_MODE0) >= 0) begin
        rd_nxt[7:0] = mode_r[reg_idx(paddr, `CEC_OFS_MODE0)];
    end else if (paddr == `CEC_OFS_XIE) begin
        rd_nxt[NCMP-1:0] = xie_r;
    end else if (paddr == `CEC_OFS_PIN) begin
        rd_nxt[NCMP-1:0] = pin_od_r;
    end else if (paddr == `CEC_OFS_RST) begin
        rd_nxt[NCMP-1:0] = rst_en_r;
    end else begin
        addr_ok = 1'b0;
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        for (i = 0; i < NCMP; i = i + 1) begin
            ctrl_r[i] <= `CEC_CTRL_RST;
            mode_r[i] <= `CEC_MODE_RST;
        end
        xie_r <= {NCMP{1'b0}};
        pin_od_r <= {NCMP{1'b0}};
        rst_en_r <= {NCMP{1'b0}};
        prev_r <= {NCMP{1'b0}};
        prdata <= 32'h00000000;
        cmp_irq <= 1'b0;
        cmp_reset_req <= 1'b0;
        cmp_power_on <= {NCMP{1'b0}};
        cmp_pin_out <= {NCMP{1'b0}};
        cmp_pin_oe <= {NCMP{1'b0}};
        response_time_select <= {2*NCMP{1'b0}};
        pos_hysteresis_select <= {2*NCMP{1'b0}};
        neg_hysteresis_select <= {2*NCMP{1'b0}};
    end else begin
        if (psel && !penable && !pwrite)
            prdata <= rd_nxt;
        prev_r <= cmp_output_state;
        for (i = 0; i < NCMP; i = i + 1) begin
            if (wr_en && reg_idx(paddr, `CEC_OFS_CTRL0) == i) begin
                ctrl_r[i][`CEC_B_EN] <= pwdata[`CEC_B_EN];
                ctrl_r[i][`CEC_F_HYP] <= pwdata[`CEC_F_HYP];
                ctrl_r[i][`CEC_F_HYN] <= pwdata[`CEC_F_HYN];
                // software may clear or set a flag; a new edge wins over a clear
                ctrl_r[i][`CEC_B_RIF] <= pwdata[`CEC_B_RIF] | rise_ev[i];
                ctrl_r[i][`CEC_B_FIF] <= pwdata[`CEC_B_FIF] | fall_ev[i];
            end else begin
                if (rise_ev[i])
                    ctrl_r[i][`CEC_B_RIF] <= 1'b1;
                if (fall_ev[i])
                    ctrl_r[i][`CEC_B_FIF] <= 1'b1;
            end
            if (wr_en && reg_idx(paddr, `CEC_OFS_MODE0) == i) begin
                mode_r[i] <= pwdata[7:0] & 8'h33;
            end
            cmp_power_on[i] <= ctrl_r[i][`CEC_B_EN];
            response_time_select[2*i +: 2] <= mode_r[i][`CEC_F_MD];
            pos_hysteresis_select[2*i +: 2] <= ctrl_r[i][`CEC_F_HYP];
            neg_hysteresis_select[2*i +: 2] <= ctrl_r[i][`CEC_F_HYN];
            // open drain drives only the low level
            cmp_pin_out[i] <= cmp_output_state[i];
            cmp_pin_oe[i] <= pin_od_r[i] ? ~cmp_output_state[i] : 1'b1;
        end
        if (wr_en && paddr == `CEC_OFS_XIE)
            xie_r <= pwdata[NCMP-1:0];
        if (wr_en && paddr == `CEC_OFS_PIN)
            pin_od_r <= pwdata[NCMP-1:0];
        if (wr_en && paddr == `CEC_OFS_RST)
            rst_en_r <= pwdata[NCMP-1:0];
        cmp_irq <= |irq_nxt;
        // reset fires while an enabled source reads low
        cmp_reset_req <= |(rst_en_r & ctrl_r_en(1'b0) & ~cmp_output_state);
    end
end

// enable bits of all comparators
function [NCMP-1:0] ctrl_r_en;
    input dummy;
    integer k;
    begin
        for (k = 0; k < NCMP; k = k + 1)
            ctrl_r_en[k] = ctrl_r[k][`CEC_B_EN];
    end
endfunction

endmodule // cec_top
`default_nettype wire

// >>> test/cec_analog_model.sv
// behavioural comparator cores seen through cmp_raw
`timescale 1ns/1ps
`default_nettype none
module cec_analog_model (
    // clock
    input wire logic pclk,
    // core control and input level
    input wire logic [2:0] cmp_power_on,
    input wire logic [2:0] level,
    output logic [2:0] cmp_raw
);
    initial cmp_raw = 3'h0;
    // unpowered core gives no valid result: it toggles
    always @(posedge pclk) begin
        cmp_raw <= (cmp_power_on & level) | (~cmp_power_on & ~cmp_raw);
    end
endmodule // cec_analog_model
`default_nettype wire

// >>> test/cec_top_properties.sv
// concurrent checks on the comparator edge control ports
`timescale 1ns/1ps
`default_nettype none
`include "cec_consts.vh"
module cec_top_properties #(
    parameter NCMP = 3
) (
    input wire pclk, presetn, psel, penable, pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata, prdata,
    input wire pready, pslverr,
    input wire [NCMP-1:0] cmp_raw, cmp_power_on, cmp_pin_out, cmp_pin_oe,
    input wire [2*NCMP-1:0] response_time_select, pos_hysteresis_select, neg_hysteresis_select,
    input wire cmp_reset_req, cmp_irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire wr = psel && penable && pwrite;
    a_enable_write: assert property (wr && paddr == `CEC_OFS_CTRL0 |-> ##2 cmp_power_on[0] == $past(pwdata[7], 2)) else $error("enable bit not applied");
    a_pin_low_off: assert property ((~cmp_power_on & ~$past(cmp_power_on) & cmp_pin_out) == 0) else $error("pin driven while off");
    a_ready_high: assert property (pready) else $error("pready low");
    a_unmapped_err: assert property (psel && penable && paddr == 12'h030 |-> pslverr) else $error("no slave error");
    a_mode_write: assert property (wr && paddr == `CEC_OFS_MODE0 |-> ##2 response_time_select[1:0] == $past(pwdata[1:0], 2)) else $error("response time not applied");
    a_hyst_write: assert property (wr && paddr == `CEC_OFS_CTRL1 |-> ##2 pos_hysteresis_select[3:2] == $past(pwdata[3:2], 2) && neg_hysteresis_select[3:2] == $past(pwdata[1:0], 2)) else $error("hysteresis not applied");
    a_irq_gated: assert property (wr && paddr == `CEC_OFS_XIE && pwdata[2:0] == 3'h0 |-> ##2 !cmp_irq) else $error("irq without enable");
    a_reset_power: assert property (cmp_reset_req |-> |cmp_power_on || |$past(cmp_power_on)) else $error("reset from off core");
endmodule // cec_top_properties
bind cec_top cec_top_properties #(.NCMP(NCMP)) cec_top_properties_inst (.*);
`default_nettype wire

// >>> test/comparator_edge_control_tb_top.sv
// self-checking bench for the comparator edge control block
`timescale 1ns/1ps
`default_nettype none
`include "cec_consts.vh"
module comparator_edge_control_tb_top;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, cmp_reset_req, cmp_irq;
    logic [2:0] cmp_raw, cmp_power_on, cmp_pin_out, cmp_pin_oe, level = 3'h0;
    logic [5:0] rts, hyp, hyn;
    int miscompares = 0, checks = 0;
    initial forever #5 pclk = ~pclk;
    cec_top cec_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cmp_raw(cmp_raw), .cmp_power_on(cmp_power_on),
        .response_time_select(rts), .pos_hysteresis_select(hyp), .neg_hysteresis_select(hyn),
        .cmp_pin_out(cmp_pin_out), .cmp_pin_oe(cmp_pin_oe), .cmp_reset_req(cmp_reset_req),
        .cmp_irq(cmp_irq));
    cec_analog_model cec_analog_model_inst (.pclk(pclk), .cmp_power_on(cmp_power_on),
        .level(level), .cmp_raw(cmp_raw));
    task end_of_test;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            miscompares++;
            $display("mismatch %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
        if (n >= 20) begin
            miscompares++;
            end_of_test();
        end
    endtask
    task t_reset;
        apb(0, `CEC_OFS_CTRL0, 0); chk(q, 32'h00);
        apb(0, `CEC_OFS_MODE0, 0); chk(q, 32'h02);
        chk(cmp_power_on, 3'h0);
        chk(cmp_pin_oe, 3'h7);
        $display("test reset done");
    endtask
    task t_regs;
        apb(1, `CEC_OFS_MODE1, 32'hFF); apb(0, `CEC_OFS_MODE1, 0); chk(q, 32'h33);
        chk(rts[3:2], 2'h3);
        apb(1, `CEC_OFS_CTRL1, 32'h0E); repeat (2) @(posedge pclk);
        chk({hyp[3:2], hyn[3:2]}, 4'hE);
        apb(0, 12'h030, 0); chk(err, 1);
        chk(q, 0);
        $display("test regs done");
    endtask
    task t_edges;
        apb(1, `CEC_OFS_CTRL0, 32'h80); repeat (10) @(posedge pclk);
        apb(1, `CEC_OFS_CTRL0, 32'h80); chk(cmp_power_on[0], 1);
        apb(1, `CEC_OFS_MODE0, 32'h20); apb(1, `CEC_OFS_XIE, 32'h1);
        level <= 3'h1; repeat (6) @(posedge pclk);
        apb(0, `CEC_OFS_CTRL0, 0); chk(q, 32'hE0);
        chk({cmp_irq, cmp_pin_out[0]}, 2'b11);
        apb(1, `CEC_OFS_CTRL0, 32'h80); repeat (3) @(posedge pclk); chk(cmp_irq, 0);
        level <= 3'h0; repeat (6) @(posedge pclk);
        apb(0, `CEC_OFS_CTRL0, 0); chk(q, 32'h90); chk(cmp_irq, 0);
        apb(1, `CEC_OFS_RST, 32'h1); repeat (3) @(posedge pclk); chk(cmp_reset_req, 1);
        apb(1, `CEC_OFS_PIN, 32'h1); repeat (2) @(posedge pclk);
        chk({cmp_pin_oe[0], cmp_pin_out[0]}, 2'b10);
        apb(1, `CEC_OFS_RST, 0); apb(1, `CEC_OFS_XIE, 0); apb(1, `CEC_OFS_CTRL0, 32'h80);
        level <= 3'h1; repeat (6) @(posedge pclk); chk(cmp_irq, 0);
        chk(cmp_pin_oe[0], 0);
        apb(1, `CEC_OFS_CTRL0, 32'h00); repeat (4) @(posedge pclk);
        chk({cmp_power_on[0], cmp_pin_out[0]}, 2'b00);
        apb(0, `CEC_OFS_CTRL0, 0); chk(q[7:6], 2'b00);
        $display("test edges done");
    endtask
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1;
        t_reset();
        t_regs();
        t_edges();
        end_of_test();
    end
endmodule // comparator_edge_control_tb_top
`default_nettype wire
